// *** hdl/cbrs_top.sv ***
/*
 * Camera boot and reset select: shared open-drain power-on reset line,
 * image-select sampling at boot, camera control mapping, sync routing,
 * camera clock enable and an APB register port.
 * Assumes pins arrive asynchronously and a 33.333 MHz clock generator
 * outside this block is gated by sys_clk_out_en.
 */
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module cbrs_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Shared open-drain reset line
	input wire logic shared_power_on_reset_n_in,
	output logic shared_power_on_reset_n_out,
	output logic shared_power_on_reset_n_oe,
	input wire logic supplies_good,
	// Image select pins
	input wire logic image_select_bit0,
	input wire logic image_select_bit1,
	output logic boot_image_main,
	output logic boot_image_valid,
	// Controller outputs and camera controls
	input wire logic logic_controller_out_a,
	input wire logic logic_controller_out_b,
	input wire logic logic_controller_out_c,
	input wire logic logic_controller_out_d,
	output logic camera_control_out1,
	output logic camera_control_out2,
	output logic camera_control_out3,
	output logic camera_control_out4,
	// Video sync
	input wire logic frame_valid_in,
	input wire logic line_valid_in,
	input wire logic data_valid_in,
	input wire logic plc_frame_valid,
	input wire logic plc_line_valid,
	output logic acq_frame_valid,
	output logic acq_line_valid,
	output logic acq_data_valid,
	// Device-wide reset effects
	output logic core_idle,
	output logic mem_flush,
	output logic host_drop,
	output logic ip_clear,
	output logic sys_clk_out_en
);

	typedef enum {ST_POWERUP, ST_RUN, ST_IDLE} cbrs_state_t;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [cbrs_pkg::SYNC_W-1:0] pins_async;
	logic [cbrs_pkg::SYNC_W-1:0] pins_sync;
	logic line_s;
	logic pgood_s;
	logic [1:0] sel_s;
	cbrs_pkg::cbrs_sync_t cam_s;

	assign pins_async = {shared_power_on_reset_n_in, supplies_good, image_select_bit1,
		image_select_bit0, frame_valid_in, line_valid_in, data_valid_in};

	// Line resets to high so a released line is not seen as a request
	cbrs_sync2 #(
		.WIDTH(cbrs_pkg::SYNC_W),
		.INIT(7'h40)
	) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	assign line_s = pins_sync[6];
	assign pgood_s = pins_sync[5];
	assign sel_s = pins_sync[4:3];
	assign cam_s = pins_sync[2:0];

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	cbrs_state_t state_r, state_nxt;
	logic [cbrs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [1:0] image_r, image_nxt;
	logic boot_done_r, boot_done_nxt;
	logic drive_r, drive_nxt;
	logic flush_r, flush_nxt;
	logic [31:0] rstcnt_r, rstcnt_nxt;
	logic req_seen;

	// A request counts only after the line stays low for the full time
	assign req_seen = (cnt_r >= cbrs_pkg::CNT_W'(cbrs_pkg::RST_REQ_MIN_CYC - 1)) && !line_s;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		image_nxt = image_r;
		boot_done_nxt = boot_done_r;
		drive_nxt = drive_r;
		flush_nxt = 1'b0;
		rstcnt_nxt = rstcnt_r;
		case (state_r)
			ST_POWERUP: begin
				drive_nxt = 1'b1;
				if (cnt_r < cbrs_pkg::CNT_W'(cbrs_pkg::PWR_HOLD_CYC)) begin
					cnt_nxt = cnt_r + 1'b1;
				end else if (pgood_s) begin
					drive_nxt = 1'b0;
					image_nxt = sel_s;
					boot_done_nxt = 1'b1;
					cnt_nxt = '0;
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				// Low time is measured on the synchronised line only
				if (line_s) begin
					cnt_nxt = '0;
				end else if (req_seen) begin
					state_nxt = ST_IDLE;
					flush_nxt = 1'b1;
					rstcnt_nxt = rstcnt_r + 32'h1;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + 1'b1;
				end
			end
			ST_IDLE: begin
				// Stays idle as long as the camera holds the line
				if (line_s) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_POWERUP;
				cnt_nxt = '0;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= ST_POWERUP;
			cnt_r <= '0;
			image_r <= cbrs_pkg::IMAGE_BACKUP;
			boot_done_r <= 1'b0;
			drive_r <= 1'b1;
			flush_r <= 1'b0;
			rstcnt_r <= 32'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			image_r <= image_nxt;
			boot_done_r <= boot_done_nxt;
			drive_r <= drive_nxt;
			flush_r <= flush_nxt;
			rstcnt_r <= rstcnt_nxt;
		end
	end

	// Open drain: the output level is always low, only the enable moves
	assign shared_power_on_reset_n_out = 1'b0;
	assign shared_power_on_reset_n_oe = drive_r;
	assign mem_flush = flush_r;
	assign host_drop = flush_r;
	assign ip_clear = flush_r;

	// ----------------------------------------------------------------
	// Outputs: idle, boot image, controls, sync, clock enable
	// ----------------------------------------------------------------
	logic [2:0] ctrl_r, ctrl_nxt;
	logic idle_nxt;
	logic [3:0] cc_r, cc_nxt;
	cbrs_pkg::cbrs_sync_t acq_r, acq_nxt;
	logic main_r, main_nxt;
	logic valid_r, valid_nxt;
	logic clken_r, clken_nxt;
	logic idle_r;

	always_comb begin
		idle_nxt = (state_nxt != ST_RUN);
		main_nxt = boot_done_nxt && (image_nxt == cbrs_pkg::IMAGE_MAIN);
		valid_nxt = boot_done_nxt && ((image_nxt == cbrs_pkg::IMAGE_MAIN)
			|| (image_nxt == cbrs_pkg::IMAGE_BACKUP));
		// Controls stay low while idle so the camera sees no stray pulses
		cc_nxt = idle_nxt ? 4'h0 : {logic_controller_out_d, logic_controller_out_c,
			logic_controller_out_b, logic_controller_out_a};
		if (ctrl_r[cbrs_pkg::CTRL_PLC_SYNC_BIT]) begin
			acq_nxt.frame = plc_frame_valid;
			acq_nxt.line = plc_line_valid;
		end else begin
			// Missing frame valid is treated as always high
			acq_nxt.frame = ctrl_r[cbrs_pkg::CTRL_FRAME_VALID_IN_PRESENT_BIT] ? cam_s.frame : 1'b1;
			acq_nxt.line = cam_s.line;
		end
		// Missing data valid follows line valid
		acq_nxt.data = ctrl_r[cbrs_pkg::CTRL_DATA_VALID_IN_PRESENT_BIT] ? cam_s.data : acq_nxt.line;
		if (idle_nxt) begin
			acq_nxt = '0;
		end
		clken_nxt = boot_done_nxt;
	end

	// Output registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			idle_r <= 1'b1;
			main_r <= 1'b0;
			valid_r <= 1'b0;
			cc_r <= 4'h0;
			acq_r <= '0;
			clken_r <= 1'b0;
		end else begin
			idle_r <= idle_nxt;
			main_r <= main_nxt;
			valid_r <= valid_nxt;
			cc_r <= cc_nxt;
			acq_r <= acq_nxt;
			clken_r <= clken_nxt;
		end
	end

	assign core_idle = idle_r;
	assign boot_image_main = main_r;
	assign boot_image_valid = valid_r;
	assign camera_control_out1 = cc_r[0];
	assign camera_control_out2 = cc_r[1];
	assign camera_control_out3 = cc_r[2];
	assign camera_control_out4 = cc_r[3];
	assign acq_frame_valid = acq_r.frame;
	assign acq_line_valid = acq_r.line;
	assign acq_data_valid = acq_r.data;
	assign sys_clk_out_en = clken_r;

	// ----------------------------------------------------------------
	// APB register port
	// ----------------------------------------------------------------
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic access;
	logic hit;
	logic [31:0] status_w;

	assign access = psel && penable && pready_r;
	assign hit = (paddr == cbrs_pkg::CTRL_OFS) || (paddr == cbrs_pkg::STATUS_OFS)
		|| (paddr == cbrs_pkg::RSTCNT_OFS);

	always_comb begin
		status_w = 32'h0;
		status_w[cbrs_pkg::STAT_IMAGE_LSB +: 2] = image_r;
		status_w[cbrs_pkg::STAT_BOOT_DONE_BIT] = boot_done_r;
		status_w[cbrs_pkg::STAT_IDLE_BIT] = idle_r;
		status_w[cbrs_pkg::STAT_DRIVING_BIT] = drive_r;
		status_w[cbrs_pkg::STAT_LINE_BIT] = line_s;
		status_w[cbrs_pkg::STAT_RESERVED_BIT] = boot_done_r && !valid_r;
		// Answer lands one cycle after setup: no wait states
		pready_nxt = psel && !penable;
		pslverr_nxt = psel && !penable && !hit;
		prdata_nxt = 32'h0;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				cbrs_pkg::CTRL_OFS: prdata_nxt = {29'h0, ctrl_r};
				cbrs_pkg::STATUS_OFS: prdata_nxt = status_w;
				cbrs_pkg::RSTCNT_OFS: prdata_nxt = rstcnt_r;
				default: prdata_nxt = 32'h0;
			endcase
		end
		ctrl_nxt = ctrl_r;
		if (access && pwrite && (paddr == cbrs_pkg::CTRL_OFS)) begin
			ctrl_nxt = pwdata[2:0];
		end
		// Idle reset discards software settings
		if (state_r == ST_IDLE) begin
			ctrl_nxt = cbrs_pkg::CTRL_RESET;
		end
	end

	// Bus registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_r <= cbrs_pkg::CTRL_RESET;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

endmodule : cbrs_top

`default_nettype wire

// *** hdl/cbrs_pkg.sv ***
/*
 * Constants and types shared by the camera boot/reset select block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 40 MHz ref_clk and a 32-bit APB register port.
 */
package cbrs_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int REF_CLK_HZ = 40000000;
	localparam int REF_CLK_PERIOD_NS = 25;
	// Least low time of a camera reset request, rounded up to cycles
	localparam int RST_REQ_MIN_NS = 500;
	localparam int RST_REQ_MIN_CYC =
		(RST_REQ_MIN_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	// Least time the line is held low after power-up, in cycles
	localparam int PWR_HOLD_NS = 1000;
	localparam int PWR_HOLD_CYC =
		(PWR_HOLD_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] RSTCNT_OFS = 8'h08;

	// CTRL fields
	localparam int CTRL_FRAME_VALID_IN_PRESENT_BIT = 0;
	localparam int CTRL_DATA_VALID_IN_PRESENT_BIT = 1;
	localparam int CTRL_PLC_SYNC_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// STATUS fields
	localparam int STAT_IMAGE_LSB = 0;
	localparam int STAT_BOOT_DONE_BIT = 2;
	localparam int STAT_IDLE_BIT = 3;
	localparam int STAT_DRIVING_BIT = 4;
	localparam int STAT_LINE_BIT = 5;
	localparam int STAT_RESERVED_BIT = 6;

	// Image select codes
	localparam logic [1:0] IMAGE_BACKUP = 2'h0;
	localparam logic [1:0] IMAGE_MAIN = 2'h3;

	// Synchronised pin group width
	localparam int SYNC_W = 7;

	// Frame, line and data valid travelling together
	typedef struct packed {
		logic frame;
		logic line;
		logic data;
	} cbrs_sync_t;

endpackage : cbrs_pkg

// *** hdl/cbrs_sync2.sv ***
/*
 * Two-flip-flop synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; no bus coherence across bits.
 */
`timescale 1ns/10ps
`default_nettype none

module cbrs_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_r <= INIT;
			sync_out <= INIT;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : cbrs_sync2

`default_nettype wire

// *** tb/cbrs_cam_model.sv ***
/*
 * Camera head model on the shared power-on reset line.
 * Assumes the board pull-up and a bench-driven request input.
 */
`timescale 1ns/10ps
`default_nettype none

module cbrs_cam_model (
	input wire logic dut_oe,
	input wire logic cam_pull,
	output logic line
);
	// ----------------------------------------
	// Wired line
	// ----------------------------------------
	// Open-drain only and no pull-down, so the pull-up wins when both let go
	assign line = !(dut_oe || cam_pull);
endmodule : cbrs_cam_model

`default_nettype wire

// *** tb/cbrs_top_props.sv ***
/*
 * Concurrent checks on the camera boot and reset select ports.
 * Assumes one clock domain and bench-held image-select pins.
 */
`timescale 1ns/10ps
`default_nettype none

module cbrs_top_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic shared_power_on_reset_n_in,
	input wire logic shared_power_on_reset_n_out,
	input wire logic shared_power_on_reset_n_oe,
	input wire logic image_select_bit0,
	input wire logic boot_image_main,
	input wire logic boot_image_valid,
	input wire logic logic_controller_out_a,
	input wire logic logic_controller_out_b,
	input wire logic logic_controller_out_c,
	input wire logic logic_controller_out_d,
	input wire logic camera_control_out1,
	input wire logic camera_control_out2,
	input wire logic camera_control_out3,
	input wire logic camera_control_out4,
	input wire logic core_idle,
	input wire logic mem_flush,
	input wire logic host_drop,
	input wire logic ip_clear
);
	// ----------------------------------------
	// Low-time counter
	// ----------------------------------------
	logic [5:0] lo_cnt_r;
	logic [5:0] lo_cnt_nxt;

	// Saturates so a long hold never wraps back to a short count
	always_comb begin
		lo_cnt_nxt = shared_power_on_reset_n_in ? 6'h00 : lo_cnt_r + {5'h00, lo_cnt_r != 6'h3f};
	end
	always_ff @(posedge ref_clk) begin
		lo_cnt_r <= lo_cnt_nxt;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_entry;
		$rose(core_idle);
	endsequence
	sequence s_pulses;
		mem_flush && host_drop && ip_clear ##1 !mem_flush && !host_drop && !ip_clear;
	endsequence

	a_hold_after_rst: assert property ($fell(sys_rst) |-> shared_power_on_reset_n_oe [*8])
		else $error("line released too soon after reset");
	a_drive_low: assert property (shared_power_on_reset_n_out == 1'b0)
		else $error("line driven high");
	a_cc_map: assert property (!core_idle && !$past(core_idle) |->
		{camera_control_out4, camera_control_out3, camera_control_out2, camera_control_out1}
		== $past({logic_controller_out_d, logic_controller_out_c,
		logic_controller_out_b, logic_controller_out_a}))
		else $error("camera control mapping wrong");
	a_entry_pulse: assert property (s_entry |-> s_pulses)
		else $error("idle entry pulses wrong");
	a_entry_len: assert property (s_entry |-> lo_cnt_r >= 6'd20)
		else $error("idle entered on a short low");
	a_long_low: assert property (lo_cnt_r == 6'd26 |-> core_idle)
		else $error("long low not seen as request");
	// Power-up hold is the block's own drive, so only a line it has let go counts here
	a_idle_stand: assert property (core_idle && !shared_power_on_reset_n_in &&
		!shared_power_on_reset_n_oe |=> core_idle)
		else $error("idle left while line low");
	a_boot_code: assert property (boot_image_valid |-> boot_image_main == image_select_bit0)
		else $error("boot image code wrong");
endmodule : cbrs_top_props

`default_nettype wire

bind cbrs_top cbrs_top_props i_props (.ref_clk, .sys_rst, .shared_power_on_reset_n_in,
	.shared_power_on_reset_n_out, .shared_power_on_reset_n_oe, .image_select_bit0,
	.boot_image_main, .boot_image_valid, .logic_controller_out_a, .logic_controller_out_b,
	.logic_controller_out_c, .logic_controller_out_d, .camera_control_out1,
	.camera_control_out2, .camera_control_out3, .camera_control_out4, .core_idle,
	.mem_flush, .host_drop, .ip_clear);

// *** tb/test_camera_boot_reset_select.sv ***
/*
 * Self-checking bench: boot codes, control mapping, sync routing, resets.
 * Assumes the camera model on the shared line and an APB master here.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH %0t %h %h", $time, a, b); end end

module test_camera_boot_reset_select;
	logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, line, oe, sg = 0, s0 = 0, s1 = 0, pull = 0;
	logic fv = 0, lv = 0, dv = 0, pfv = 0, plv = 0, bm, bv, ci, ce;
	logic [3:0] lc = 4'h0, cc;
	logic [2:0] acq;
	int failures = 0, n_tests = 0;

	cbrs_top i_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .shared_power_on_reset_n_in(line), .shared_power_on_reset_n_out(),
		.shared_power_on_reset_n_oe(oe), .supplies_good(sg), .image_select_bit0(s0),
		.image_select_bit1(s1), .boot_image_main(bm), .boot_image_valid(bv),
		.logic_controller_out_a(lc[0]), .logic_controller_out_b(lc[1]),
		.logic_controller_out_c(lc[2]), .logic_controller_out_d(lc[3]),
		.camera_control_out1(cc[0]), .camera_control_out2(cc[1]),
		.camera_control_out3(cc[2]), .camera_control_out4(cc[3]), .frame_valid_in(fv),
		.line_valid_in(lv), .data_valid_in(dv), .plc_frame_valid(pfv), .plc_line_valid(plv),
		.acq_frame_valid(acq[2]), .acq_line_valid(acq[1]), .acq_data_valid(acq[0]),
		.core_idle(ci), .mem_flush(), .host_drop(), .ip_clear(), .sys_clk_out_en(ce));
	cbrs_cam_model i_cam (.dut_oe(oe), .cam_pull(pull), .line);

	// ----------------------------------------
	// Clock, tasks, watchdog
	// ----------------------------------------
	initial begin
		forever #12.5 ref_clk = !ref_clk;
	end

	task automatic results();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results

	// Request held until pready is seen high at an edge
	// A missing answer is left to the watchdog, which fails the run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata; e = pslverr;
		psel <= 0; penable <= 0;
	endtask : apb

	// Reset, hold supplies off, then let the line go
	task automatic boot(input logic [1:0] c);
		sys_rst <= 1; {s1, s0} <= c; sg <= 0;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 0;
		repeat (60) @(posedge ref_clk);
		`CHK(oe, 1'b1)
		sg <= 1;
		repeat (10) @(posedge ref_clk);
		`CHK(line, 1'b1)
		`CHK(ci, 1'b0)
	endtask : boot

	initial begin
		#200000;
		failures++;
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		for (int c = 0; c < 4; c++) begin
			boot(c[1:0]);
			`CHK(bv, c == 0 || c == 3)
			`CHK(bm, c == 3)
			`CHK(ce, 1'b1)
			apb(0, cbrs_pkg::STATUS_OFS, 32'h0);
			`CHK(q[1:0], c[1:0])
			`CHK(q[6], c == 1 || c == 2)
		end
		for (int p = 0; p < 16; p++) begin
			lc <= p[3:0];
			repeat (3) @(posedge ref_clk);
			`CHK(cc, p[3:0])
		end
		// Line valid alone must be enough to capture
		lv <= 1;
		repeat (6) @(posedge ref_clk);
		`CHK(acq, 3'h7)
		apb(0, cbrs_pkg::CTRL_OFS, 32'h0);
		`CHK(q, 32'h0)
		apb(1, cbrs_pkg::CTRL_OFS, 32'h4);
		repeat (4) @(posedge ref_clk);
		`CHK(acq, 3'h0)
		plv <= 1;
		pfv <= 1;
		repeat (3) @(posedge ref_clk);
		`CHK(acq, 3'h7)
		apb(0, 8'h10, 32'h0);
		`CHK({e, q}, 33'h100000000)
		// Camera frame and data valid marked present: each pin is taken as it stands
		apb(1, cbrs_pkg::CTRL_OFS, 32'h3);
		apb(0, cbrs_pkg::CTRL_OFS, 32'h0);
		`CHK(q, 32'h3)
		`CHK(acq, 3'h2)
		fv <= 1;
		repeat (4) @(posedge ref_clk);
		`CHK(acq, 3'h6)
		// Short low is ignored, long low idles the core and clears control
		for (int k = 15; k < 50; k += 25) begin
			pull <= 1;
			repeat (k) @(posedge ref_clk);
			`CHK(ci, k == 40)
			`CHK(cc, k == 40 ? 4'h0 : 4'hf)
			pull <= 0;
			repeat (8) @(posedge ref_clk);
			apb(0, cbrs_pkg::RSTCNT_OFS, 32'h0);
			`CHK(q, 32'(k == 40))
		end
		apb(0, cbrs_pkg::CTRL_OFS, 32'h0);
		`CHK(q, 32'h0)
		results();
	end
endmodule : test_camera_boot_reset_select

`default_nettype wire
